// [odfs_pkg.sv]
// Package for the output driver fault supervisor: status bit positions,
// timing figures and widths. Assumes a 25 MHz core clock.
package odfs_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ          = 25000000;
  localparam int LOCKOUT_MS      = 250;
  localparam int LOCKOUT_CYC     = (CLK_HZ / 1000) * LOCKOUT_MS;
  localparam int PWM_MIN_HZ      = 33;
  localparam int PWM_MAX_HZ      = 4000;
  localparam int DITHER_MAX_HZ   = 250;
  localparam int DITHER_MAX_MA   = 500;
  localparam int PER_MAX_CYC     = CLK_HZ / PWM_MIN_HZ;
  localparam int PER_MIN_CYC     = CLK_HZ / PWM_MAX_HZ;
  localparam int DPER_MIN_CYC    = CLK_HZ / DITHER_MAX_HZ;

  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int CNT_W  = 20;
  localparam int DUTY_W = 16;
  localparam int CUR_W  = 16;
  localparam int LOCK_W = 24;

  // ----------------------------------------------------------------------
  // Status word layout
  // ----------------------------------------------------------------------
  localparam int STAT_W           = 9;
  localparam int BIT_TEMP_OPEN    = 3;
  localparam int BIT_OVERLOAD     = 4;
  localparam int BIT_BAD_MODE     = 5;
  localparam int BIT_SAFETY_FAIL  = 6;
  localparam int BIT_SWITCH_OFF   = 7;
  localparam int BIT_SUPPLY_RANGE = 8;

  typedef enum logic [1:0] {
    ODFS_MODE_OPEN,
    ODFS_MODE_CLOSED,
    ODFS_MODE_BAD0,
    ODFS_MODE_BAD1
  } odfs_mode_t;

  typedef enum logic [1:0] {
    ODFS_ARMED,
    ODFS_TRIPPED,
    ODFS_WAIT_ZERO
  } odfs_trip_t;
endpackage

// [odfs_pwm_gen.sv]
// PWM core with triangular dither added to the level input.
// Assumes period and duty come from the same clock domain.
`timescale 1ns/1ps
module odfs_pwm_gen #(
  parameter int CW = odfs_pkg::CNT_W,
  parameter int DW = odfs_pkg::DUTY_W
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic [CW-1:0] period,
  input  wire logic [DW-1:0] level,
  input  wire logic [DW-1:0] dither_amp,
  input  wire logic [CW-1:0] dither_step_cyc,
  input  wire logic          dither_en,
  output logic               pwm_q
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] dcnt_q;
  logic          dup_q;
  logic [DW-1:0] dofs_q;
  logic [DW:0]   eff;
  logic [CW-1:0] per_eff;

  // Period is clamped to the 33 Hz to 4000 Hz window.
  always_comb
  begin
    per_eff = period;
    if (period > CW'(odfs_pkg::PER_MAX_CYC))
      per_eff = CW'(odfs_pkg::PER_MAX_CYC);
    if (period < CW'(odfs_pkg::PER_MIN_CYC))
      per_eff = CW'(odfs_pkg::PER_MIN_CYC);
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cnt_q <= '0;
    else if (cnt_q >= per_eff - CW'(1))
      cnt_q <= '0;
    else
      cnt_q <= cnt_q + CW'(1);
  end

  // Dither walks one step per dither_step_cyc + 1 cycles; odfs_top floors dither_step_cyc at 100,
  // which keeps the dither under 250 Hz only for an amplitude of 495 or more.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dcnt_q <= '0;
      dofs_q <= '0;
      dup_q  <= 1'b1;
    end
    else if (!dither_en)
    begin
      dcnt_q <= '0;
      dofs_q <= '0;
      dup_q  <= 1'b1;
    end
    else if (dcnt_q >= dither_step_cyc)
    begin
      dcnt_q <= '0;
      if (dup_q && dofs_q >= dither_amp)
        dup_q <= 1'b0;
      else if (!dup_q && dofs_q == '0)
        dup_q <= 1'b1;
      else if (dup_q)
        dofs_q <= dofs_q + DW'(1);
      else
        dofs_q <= dofs_q - DW'(1);
    end
    else
      dcnt_q <= dcnt_q + CW'(1);
  end

  always_comb
  begin
    eff = {1'b0, level} + {1'b0, dofs_q};
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      pwm_q <= 1'b0;
    else
      pwm_q <= (level != '0) && ((CW + 1)'(eff) > {1'b0, cnt_q});
  end
endmodule

// [odfs_top.sv]
// Output driver fault supervisor: one protected PWM channel with fault
// flags, over-current latch and redundant supply switch lockout.
// Assumes analog comparisons arrive as pins and current samples as words.
//
// Summary of operation
// - Temperature/open-load flag clears only when commanded off and temperature valid.
// - Safety-layer failure flag clears only at power-on reset.
// - Switch-off flag clears after 250 ms off and output commanded off.
// - Supply flag clears only when supply back in range; host commands outputs off.
// - Two modes: open-loop duty and closed-loop current.
// - Open loop drives duty only; current sampled for monitoring.
// - Closed loop over-maximum current shuts output down and latches.
// - After over-current shutdown output stays unpowered at least 250 ms.
// - Latched output re-arms only after command returns to zero.
// - PWM frequency configurable from 33 Hz to 4000 Hz.
// - Optional stepped dither, step floored at 101 cycles; under 250 Hz only for amplitude 495 or more.
// - Output sourced through primary switch and redundant switch in series.
// - Redundant switch held off 250 ms before re-enable accepted.
// - Output sources only while redundant switch is enabled.
// - Switch states fed back: digital to secondary, current to primary.
`timescale 1ns/1ps
module odfs_top #(
  parameter int LOCKOUT_CYC = odfs_pkg::LOCKOUT_CYC,
  parameter int CW          = odfs_pkg::CNT_W,
  parameter int DW          = odfs_pkg::DUTY_W,
  parameter int IW          = odfs_pkg::CUR_W
) (
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  input  wire logic [1:0]                 mode_sel,
  input  wire logic                       digital_cfg,
  input  wire logic                       cmd_on,
  input  wire logic [DW-1:0]              cmd_level,
  input  wire logic [CW-1:0]              pwm_period,
  input  wire logic                       dither_en,
  input  wire logic [DW-1:0]              dither_amp,
  input  wire logic [CW-1:0]              dither_step_cyc,
  input  wire logic [IW-1:0]              meas_current,
  input  wire logic [IW-1:0]              max_current,
  input  wire logic                       trip_pin,
  input  wire logic                       trip_clear,
  input  wire logic                       temp_open_pin,
  input  wire logic                       temp_ok_pin,
  input  wire logic                       supply_bad_pin,
  input  wire logic                       safety_fail_pin,
  input  wire logic                       sec_switch_req,
  output logic                            drive_q,
  output logic                            sec_switch_q,
  output logic                            sec_switch_fb_q,
  output logic [IW-1:0]                   prim_current_fb_q,
  output logic [odfs_pkg::STAT_W-1:0]     status_q
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  localparam int NP = 6;
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_q;
  logic [NP-1:0] s2_q;
  assign pin_raw = {trip_pin, temp_open_pin, temp_ok_pin, supply_bad_pin,
                    safety_fail_pin, sec_switch_req};

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_q <= '0;
      s2_q <= '0;
    end
    else
    begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
    end
  end

  logic trip_s, temp_open_s, temp_ok_s, supply_bad_s, safety_fail_s, sw_req_s;
  assign {trip_s, temp_open_s, temp_ok_s, supply_bad_s, safety_fail_s, sw_req_s} = s2_q;

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  logic cmd_zero;
  logic mode_bad;
  logic mode_closed;
  assign cmd_zero    = digital_cfg ? !cmd_on : (!cmd_on || cmd_level == '0);
  assign mode_bad    = mode_sel[1];
  assign mode_closed = (mode_sel == odfs_pkg::ODFS_MODE_CLOSED);

  // ----------------------------------------------------------------------
  // Redundant switch with 250 ms hold-off
  // ----------------------------------------------------------------------
  logic [odfs_pkg::LOCK_W-1:0] sw_cnt_q;
  logic                        sw_held;
  assign sw_held = (sw_cnt_q != '0);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sec_switch_q <= 1'b0;
      sw_cnt_q     <= odfs_pkg::LOCK_W'(LOCKOUT_CYC);
    end
    else if (!sw_req_s)
    begin
      sec_switch_q <= 1'b0;
      if (sec_switch_q)
        sw_cnt_q <= odfs_pkg::LOCK_W'(LOCKOUT_CYC);
      else if (sw_held)
        sw_cnt_q <= sw_cnt_q - 1'b1;
    end
    else if (sw_held)
      sw_cnt_q <= sw_cnt_q - 1'b1;
    else if (status_q[odfs_pkg::BIT_SWITCH_OFF] && !cmd_zero)
      sec_switch_q <= 1'b0;
    else
      sec_switch_q <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Over-current latch and re-power lockout
  // ----------------------------------------------------------------------
  odfs_pkg::odfs_trip_t        trip_q;
  logic [odfs_pkg::LOCK_W-1:0] oc_cnt_q;
  logic                        over_max;
  assign over_max = mode_closed && drive_q && (meas_current > max_current);

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trip_q   <= odfs_pkg::ODFS_ARMED;
      oc_cnt_q <= '0;
    end
    else
    begin
      if (oc_cnt_q != '0)
        oc_cnt_q <= oc_cnt_q - 1'b1;
      unique case (trip_q)
        odfs_pkg::ODFS_ARMED:
          if (over_max || trip_s)
          begin
            trip_q   <= over_max ? odfs_pkg::ODFS_WAIT_ZERO : odfs_pkg::ODFS_TRIPPED;
            oc_cnt_q <= odfs_pkg::LOCK_W'(LOCKOUT_CYC);
          end
        odfs_pkg::ODFS_TRIPPED:
          if (trip_clear && !trip_s)
            trip_q <= odfs_pkg::ODFS_ARMED;
        odfs_pkg::ODFS_WAIT_ZERO:
          if (cmd_zero && oc_cnt_q == '0)
            trip_q <= odfs_pkg::ODFS_ARMED;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Fault flags, sticky except bad mode, switch-off and supply range; a set always beats a clear
  // ----------------------------------------------------------------------
  logic [odfs_pkg::STAT_W-1:0] set_v;
  logic [odfs_pkg::STAT_W-1:0] clr_v;
  always_comb
  begin
    set_v = '0;
    clr_v = '0;
    set_v[odfs_pkg::BIT_TEMP_OPEN]    = temp_open_s;
    clr_v[odfs_pkg::BIT_TEMP_OPEN]    = cmd_zero && temp_ok_s;
    set_v[odfs_pkg::BIT_OVERLOAD]     = trip_q == odfs_pkg::ODFS_ARMED && (over_max || trip_s);
    clr_v[odfs_pkg::BIT_OVERLOAD]     = trip_q == odfs_pkg::ODFS_ARMED;
    set_v[odfs_pkg::BIT_BAD_MODE]     = mode_bad;
    clr_v[odfs_pkg::BIT_BAD_MODE]     = 1'b1;
    set_v[odfs_pkg::BIT_SAFETY_FAIL]  = safety_fail_s;
    set_v[odfs_pkg::BIT_SWITCH_OFF]   = !sec_switch_q;
    clr_v[odfs_pkg::BIT_SWITCH_OFF]   = sec_switch_q;
    set_v[odfs_pkg::BIT_SUPPLY_RANGE] = supply_bad_s;
    clr_v[odfs_pkg::BIT_SUPPLY_RANGE] = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      status_q <= '0;
    else
      status_q <= set_v | (status_q & ~clr_v);
  end

  // ----------------------------------------------------------------------
  // Drive path
  // ----------------------------------------------------------------------
  logic pwm_raw;
  logic enable;
  assign enable = !cmd_zero && !mode_bad && trip_q == odfs_pkg::ODFS_ARMED
                  && oc_cnt_q == '0 && !status_q[odfs_pkg::BIT_SAFETY_FAIL]
                  && !status_q[odfs_pkg::BIT_TEMP_OPEN]
                  && !status_q[odfs_pkg::BIT_SUPPLY_RANGE];

  // In closed loop the level is a current target; the crude bang-bang
  // regulator trades ripple for area, open loop ignores current.
  logic [DW-1:0] reg_level;
  assign reg_level = !mode_closed ? cmd_level :
                     (IW'(meas_current) < IW'(cmd_level) ? {DW{1'b1}} : '0);

  odfs_pwm_gen #(
    .CW (CW),
    .DW (DW)
  ) u_pwm (
    .core_clk        (core_clk),
    .rstn            (rstn),
    .period          (pwm_period),
    .level           (digital_cfg ? {DW{1'b1}} : reg_level),
    .dither_amp      (dither_amp),
    .dither_step_cyc (dither_step_cyc < CW'(odfs_pkg::DPER_MIN_CYC / (2 * odfs_pkg::DITHER_MAX_MA))
                      ? CW'(odfs_pkg::DPER_MIN_CYC / (2 * odfs_pkg::DITHER_MAX_MA))
                      : dither_step_cyc),
    .dither_en       (dither_en && !digital_cfg),
    .pwm_q           (pwm_raw)
  );

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      drive_q           <= 1'b0;
      sec_switch_fb_q   <= 1'b0;
      prim_current_fb_q <= '0;
    end
    else
    begin
      drive_q           <= pwm_raw && enable && sec_switch_q;
      sec_switch_fb_q   <= sec_switch_q;
      prim_current_fb_q <= meas_current;
    end
  end
endmodule

// [odfs_top_chk_sva.sv]
// Checker for odfs_top: timing of fault flags, drive and redundant switch.
// Assumes LOCKOUT_CYC equals the value given to the design instance.
`timescale 1ns/1ps
module odfs_top_chk #(
  parameter int LOCKOUT_CYC = odfs_pkg::LOCKOUT_CYC
) (
  input wire logic                         core_clk,
  input wire logic                         rstn,
  input wire logic [1:0]                   mode_sel,
  input wire logic                         supply_bad_pin,
  input wire logic                         drive_q,
  input wire logic                         sec_switch_q,
  input wire logic                         sec_switch_fb_q,
  input wire logic [odfs_pkg::STAT_W-1:0]  status_q
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------------------------------------
  // Helper: cycles the redundant switch has been off
  // ----------------------------------------------------------------------
  int low_cnt;
  always_ff @(posedge core_clk or negedge rstn)
    if (!rstn)
      low_cnt <= 0;
    else if (sec_switch_q)
      low_cnt <= 0;
    else
      low_cnt <= low_cnt + 1;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_safety_sticky: assert property (status_q[6] |=> status_q[6])
    else $error("safety failure flag dropped");
  a_drive_needs_switch: assert property (!sec_switch_q [*3] |-> !drive_q)
    else $error("drive while redundant switch off");
  a_overload_cuts: assert property ($rose(status_q[4]) |=> !drive_q [*3])
    else $error("drive after overload");
  a_switch_hold: assert property ($rose(sec_switch_q) |-> low_cnt >= LOCKOUT_CYC)
    else $error("redundant switch re-enabled too early");
  a_switch_flag: assert property ((rstn && !sec_switch_q) [*2] |-> status_q[7])
    else $error("switch-off flag missing");
  a_bad_mode: assert property (mode_sel[1] [*4] |-> status_q[5] && !drive_q)
    else $error("invalid mode not flagged");
  a_supply_clear: assert property ($fell(status_q[8]) |-> !$past(supply_bad_pin, 3))
    else $error("supply flag cleared while supply bad");
  a_fb_follows: assert property ($stable(sec_switch_q) [*3] |-> sec_switch_fb_q == sec_switch_q)
    else $error("switch feedback wrong");

  c_overload: cover property ($rose(status_q[4]));
  c_switch_on: cover property ($rose(sec_switch_q));
  c_supply_ok: cover property ($fell(status_q[8]));
endmodule

bind odfs_top odfs_top_chk #(.LOCKOUT_CYC(LOCKOUT_CYC)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .mode_sel(mode_sel), .supply_bad_pin(supply_bad_pin),
  .drive_q(drive_q), .sec_switch_q(sec_switch_q), .sec_switch_fb_q(sec_switch_fb_q),
  .status_q(status_q));

// [odfs_load.sv]
// Inductive load model: current ramps while both series switches conduct.
// Assumes drive and switch_on are registered outputs on core_clk.
`timescale 1ns/1ps
module odfs_load #(
  parameter int IW = odfs_pkg::CUR_W
) (
  input  wire logic          core_clk,
  input  wire logic          drive,
  input  wire logic          switch_on,
  output logic      [IW-1:0] current
);
  initial current = '0;
  // The coil loses a quarter of its current each cycle off, so a second trip starts from almost no current.
  always @(posedge core_clk)
    if (drive && switch_on)
      current <= (current > 16'hF000) ? current : current + 16'h0100;
    else
      current <= current - (current >> 2);
endmodule

// [testbench.sv]
// Self-checking bench for odfs_top with an inductive load model.
// Assumes a shortened lockout of LK cycles.
`timescale 1ns/1ps
module testbench;
  localparam int LK = 50;
  logic core_clk = 1'b0, rstn = 1'b0, cmd_on = 1'b0, trip_pin = 1'b0, trip_clear = 1'b0;
  logic temp_open_pin = 1'b0, temp_ok_pin = 1'b1, supply_bad_pin = 1'b0;
  logic safety_fail_pin = 1'b0, sec_switch_req = 1'b0, drive_q, sec_switch_q, sec_switch_fb_q;
  logic digital_cfg = 1'b0, dither_en = 1'b0;
  logic [15:0] dither_amp = 16'h0000;
  logic [1:0]  mode_sel = 2'h0;
  logic [15:0] cmd_level = 16'h0000, max_current = 16'hFFFF, meas_current, prim_current_fb_q;
  logic [19:0] pwm_period = 20'h01000;
  logic [8:0]  status_q;
  logic [10:0] obs, exp_q[$], msk_q[$];
  int          num_errors = 0, checks_done = 0, n, k, cur;
  event        probe;

  always #20 core_clk = ~core_clk;
  assign obs = {sec_switch_q, drive_q, status_q};

  odfs_top #(.LOCKOUT_CYC(LK)) dut (.core_clk(core_clk), .rstn(rstn), .mode_sel(mode_sel),
    .digital_cfg(digital_cfg), .cmd_on(cmd_on), .cmd_level(cmd_level), .pwm_period(pwm_period),
    .dither_en(dither_en), .dither_amp(dither_amp), .dither_step_cyc(20'h00064),
    .meas_current(meas_current), .max_current(max_current), .trip_pin(trip_pin),
    .trip_clear(trip_clear), .temp_open_pin(temp_open_pin), .temp_ok_pin(temp_ok_pin),
    .supply_bad_pin(supply_bad_pin), .safety_fail_pin(safety_fail_pin),
    .sec_switch_req(sec_switch_req), .drive_q(drive_q), .sec_switch_q(sec_switch_q),
    .sec_switch_fb_q(sec_switch_fb_q), .prim_current_fb_q(prim_current_fb_q),
    .status_q(status_q));
  odfs_load load (.core_clk(core_clk), .drive(drive_q), .switch_on(sec_switch_q),
    .current(meas_current));

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic tk(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // Outputs are sampled on the falling edge, away from the launching edge.
  task automatic wait_bit(input int sel, input logic v, output int cnt);
    cnt = 0;
    while (obs[sel] !== v)
    begin
      @(negedge core_clk);
      cnt++;
      if (cnt > 20000)
      begin
        num_errors++;
        $display("unexpected wait on bit %0d expected %b seen %b", sel, v, obs[sel]);
        end_sim;
      end
    end
  endtask

  task automatic expect_now(input logic [10:0] e, input logic [10:0] m);
    @(negedge core_clk);
    exp_q.push_back(e);
    msk_q.push_back(m);
    -> probe;
  endtask

  always @(probe)
  begin
    check("outputs", 16'(obs & msk_q[0]), 16'(exp_q[0]));
    void'(exp_q.pop_front());
    void'(msk_q.pop_front());
  end

  initial
  begin
    void'($urandom(40334));
    tk(6);
    rstn <= 1'b1;
    tk(3);
    expect_now(11'h080, 11'h7F8);
    $display("test reset done");
    tk(1);
    sec_switch_req <= 1'b1;
    wait_bit(10, 1'b1, n);
    // The hold runs from reset release, four edges before the request.
    check("hold", 16'(n + 4 >= LK), 16'h0001);
    wait_bit(7, 1'b0, n);
    tk(1);
    // Duty is counted in clock cycles, so the level must stay below the period.
    cmd_level <= 16'($urandom_range(16'h1400, 16'h0400));
    cmd_on <= 1'b1;
    wait_bit(9, 1'b1, n);
    wait_bit(9, 1'b0, n);
    wait_bit(9, 1'b1, n);
    wait_bit(9, 1'b0, n);
    wait_bit(9, 1'b1, k);
    check("period", 16'(n + k), 16'(odfs_pkg::PER_MIN_CYC));
    check("duty", 16'(n), cmd_level);
    tk(1);
    dither_en <= 1'b1;
    dither_amp <= 16'h0040;
    wait_bit(9, 1'b0, n);
    k = 0;
    repeat (2)
    begin
      wait_bit(9, 1'b1, n);
      wait_bit(9, 1'b0, n);
      check("dither", 16'(n >= cmd_level && n <= cmd_level + 16'h0040), 16'h0001);
      if (n > k)
        k = n;
    end
    check("dither moves", 16'(k > cmd_level), 16'h0001);
    tk(1);
    dither_en <= 1'b0;
    $display("test open loop done");
    tk(1);
    sec_switch_req <= 1'b0;
    wait_bit(10, 1'b0, n);
    expect_now(11'h080, 11'h280);
    tk(1);
    sec_switch_req <= 1'b1;
    tk(3 * LK);
    expect_now(11'h080, 11'h680);
    tk(1);
    cmd_on <= 1'b0;
    cmd_level <= 16'h0000;
    wait_bit(10, 1'b1, n);
    $display("test redundant switch done");
    tk(1);
    mode_sel <= 2'h1;
    max_current <= 16'h0400;
    for (k = 0; k < 2; k++)
    begin
      tk(1);
      digital_cfg <= (k == 1);
      cmd_level <= 16'hFFFF;
      cmd_on <= 1'b1;
      wait_bit(4, 1'b1, n);
      expect_now(11'h410, 11'h610);
      cur = meas_current;
      @(negedge core_clk);
      check("current feedback", prim_current_fb_q, 16'(cur));
      if (k == 0)
        tk(2 * LK);
      if (k == 0)
        expect_now(11'h010, 11'h010);
      tk(1);
      // In digital use only the on command has to fall for the re-arm.
      cmd_on <= 1'b0;
      if (k == 0)
        cmd_level <= 16'h0000;
      wait_bit(4, 1'b0, n);
      if (k == 1)
        check("lockout", 16'(n >= LK - 4), 16'h0001);
    end
    tk(1);
    digital_cfg <= 1'b0;
    cmd_level <= 16'h0000;
    trip_pin <= 1'b1;
    tk(2);
    trip_pin <= 1'b0;
    wait_bit(4, 1'b1, n);
    tk(4);
    trip_clear <= 1'b1;
    tk(1);
    trip_clear <= 1'b0;
    wait_bit(4, 1'b0, n);
    $display("test overload done");
    tk(1);
    mode_sel <= 2'h0;
    cmd_on <= 1'b1;
    cmd_level <= 16'h0100;
    temp_ok_pin <= 1'b0;
    temp_open_pin <= 1'b1;
    wait_bit(3, 1'b1, n);
    tk(1);
    temp_open_pin <= 1'b0;
    temp_ok_pin <= 1'b1;
    tk(10);
    expect_now(11'h008, 11'h008);
    tk(1);
    cmd_on <= 1'b0;
    cmd_level <= 16'h0000;
    wait_bit(3, 1'b0, n);
    tk(1);
    supply_bad_pin <= 1'b1;
    wait_bit(8, 1'b1, n);
    tk(10);
    expect_now(11'h100, 11'h100);
    tk(1);
    supply_bad_pin <= 1'b0;
    wait_bit(8, 1'b0, n);
    for (k = 2; k < 4; k++)
    begin
      tk(1);
      mode_sel <= 2'(k);
      wait_bit(5, 1'b1, n);
      expect_now(11'h020, 11'h220);
      tk(1);
      mode_sel <= 2'h0;
      wait_bit(5, 1'b0, n);
    end
    $display("test fault flags done");
    tk(1);
    safety_fail_pin <= 1'b1;
    tk(3);
    safety_fail_pin <= 1'b0;
    wait_bit(6, 1'b1, n);
    tk(20);
    expect_now(11'h040, 11'h040);
    $display("test safety failure done");
    end_sim;
  end
endmodule
